// ---- modal_status_query_responder.sv ----
// Modal status query responder: takes query commands over APB and
// renders the reply as comma-separated decimal ASCII text.
// Assumes the motion core supplies modal_in on the same clock.
//
// Operation
// - Modal-values query replies motion code, distance mode, rapid and spindle accel.
// - Reported motion code is only 0, 1, 2 or 3.
// - Distance mode reads 1 for absolute and 2 for relative.
// - Items of multi-item replies are separated by single commas only.
// - Unit query returns 0 for millimetres, 1 for inches.
// - Position query returns XYZ modal positions then XYZ pulse positions.
// - Speed query returns rapid, linear, arc then spindle speed.
// - Feedrate percent is read/write, 1 to 100, and scales feeds.
// - Offset query returns XYZ offsets and active flag; singles too.
// - Spindle query returns present RPM, read only.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module modal_status_query_responder
	import modal_query_pkg::*;
#(
	parameter logic [31:0] VERSION = 32'h0000_0001, // Arbitrary value
	parameter int DEPTH = 128
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire modal_state_t modal_in,
	output logic [6:0] feed_percent,
	output logic busy
);
	// Reply buffer address width; the fill count needs one bit more
	localparam int AW = $clog2(DEPTH);

	// ****************************************************************
	// Types and state
	// ****************************************************************
	typedef enum logic [2:0] {
		S_IDLE, S_CHECK, S_ITEM, S_CONV, S_COMMA
	} ctl_state_t;

	ctl_state_t state_reg;
	ctl_state_t state_next;
	logic [8:0] code_reg;
	logic write_reg;
	logic [31:0] wdata_reg;
	modal_state_t snap_reg;
	logic [2:0] idx_reg;
	logic ready_reg;
	logic reject_reg;

	logic [7:0] buf_data;
	logic [AW:0] buf_count;
	logic [7:0] dec_ch;
	logic dec_valid;
	logic dec_done;

	// ****************************************************************
	// Item tables
	// ****************************************************************

	// Number of reply items per query; zero marks an unknown code
	function automatic logic [2:0] item_count(input logic [8:0] code);
		unique case (code)
			Q_MODAL: item_count = 3'h4;
			Q_UNIT: item_count = 3'h1;
			Q_POS: item_count = 3'h6;
			Q_SPEED: item_count = 3'h4;
			Q_FEED: item_count = 3'h1;
			Q_OFS_ALL: item_count = 3'h4;
			Q_OFS_X, Q_OFS_Y, Q_OFS_Z, Q_OFS_ACT: item_count = 3'h1;
			Q_RPM: item_count = 3'h1;
			Q_VERSION: item_count = 3'h1;
			default: item_count = 3'h0;
		endcase
	endfunction

	// Value of one item, taken from the snapshot (feedrate and version excepted) so that a reply is
	// self-consistent even while the motion core keeps moving
	function automatic logic [31:0] item_value(
		input logic [8:0] code,
		input logic [2:0] idx,
		input modal_state_t s,
		input logic [6:0] feed
	);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (code)
			Q_MODAL: begin
				unique case (idx)
					3'h0: v = {30'h0, s.motion_code};
					3'h1: v = s.dist_relative ? DIST_REL : DIST_ABS;
					3'h2: v = s.rapid_accel;
					default: v = s.spindle_accel;
				endcase
			end
			Q_UNIT: v = {31'h0, s.unit_inch};
			Q_POS: begin
				if (idx < 3'h3) begin
					v = s.modal_pos[idx[1:0]];
				end else begin
					v = s.modal_pulse[2'(idx - 3'h3)];
				end
			end
			Q_SPEED: begin
				unique case (idx)
					3'h0: v = s.rapid_speed;
					3'h1: v = s.linear_speed;
					3'h2: v = s.arc_speed;
					default: v = s.spindle_speed;
				endcase
			end
			Q_FEED: v = {25'h0, feed};
			Q_OFS_ALL: begin
				if (idx < 3'h3) begin
					v = s.offset[idx[1:0]];
				end else begin
					v = {31'h0, s.offset_active};
				end
			end
			Q_OFS_X: v = s.offset[0];
			Q_OFS_Y: v = s.offset[1];
			Q_OFS_Z: v = s.offset[2];
			Q_OFS_ACT: v = {31'h0, s.offset_active};
			Q_RPM: v = s.spindle_rpm;
			Q_VERSION: v = VERSION;
			default: v = 32'h0000_0000;
		endcase
		item_value = v;
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************

	// Access phase needs two cycles: data is loaded, then pready rises
	wire logic access = psel & penable;
	wire logic load = access & ~pready;
	wire logic xfer = access & pready;
	wire logic wr_xfer = xfer & pwrite;
	wire logic rd_xfer = xfer & ~pwrite;

	// Register selects; any other address answers with pslverr
	wire logic sel_cmd = paddr == REG_CMD;
	wire logic sel_wdata = paddr == REG_WDATA;
	wire logic sel_status = paddr == REG_STATUS;
	wire logic sel_reply = paddr == REG_REPLY;
	wire logic sel_feed = paddr == REG_FEED;
	wire logic mapped = sel_cmd | sel_wdata | sel_status | sel_reply | sel_feed;

	// A command written while busy is dropped and flagged
	wire logic cmd_wr = wr_xfer & sel_cmd;
	wire logic cmd_take = cmd_wr & (state_reg == S_IDLE);
	wire logic cmd_lost = cmd_wr & (state_reg != S_IDLE);

	// Only a char seen valid at load time is popped, never a new one
	wire logic pop = rd_xfer & sel_reply & prdata[REPLY_VALID_BIT];

	// Status and reply words; the fill count sits in the second byte
	wire logic [31:0] status_word = {16'h0000, 8'(buf_count),
		5'h00, reject_reg, ready_reg, state_reg != S_IDLE};
	wire logic [31:0] reply_word = {23'h0, buf_count != '0, buf_data};

	// Read data multiplexer
	wire logic [31:0] rd_mux =
		sel_cmd ? {15'h0, write_reg, 7'h00, code_reg} :
		sel_wdata ? wdata_reg :
		sel_status ? status_word :
		sel_reply ? reply_word :
		sel_feed ? {25'h0, feed_percent} : 32'h0000_0000;

	// ****************************************************************
	// Command checks
	// ****************************************************************
	// Refuse an unknown code, or any write but an in-range feedrate
	wire logic [2:0] n_items = item_count(code_reg);
	wire logic feed_ok = (wdata_reg >= FEED_MIN) & (wdata_reg <= FEED_MAX);
	wire logic write_ok = write_reg & (code_reg == Q_FEED) & feed_ok;
	wire logic bad_cmd = write_reg ? ~write_ok : (n_items == 3'h0);
	wire logic last_item = (idx_reg + 3'h1) == n_items;

	// A reply is complete after its last item, or at once for any write or a refused code
	wire logic finish = ((state_reg == S_CONV) & dec_done & last_item)
		| (state_reg == S_CHECK & (write_reg | bad_cmd));

	// Character stream into the reply: digits or a separator
	wire logic comma_we = state_reg == S_COMMA;
	wire logic buf_we = dec_valid | comma_we;
	wire logic [7:0] buf_wdata = comma_we ? CH_COMMA : dec_ch;
	wire logic conv_start = state_reg == S_ITEM;
	wire logic [31:0] conv_value = item_value(code_reg, idx_reg, snap_reg,
		feed_percent);

	// ****************************************************************
	// Sequencer
	// ****************************************************************

	// Next state of the reply sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (cmd_take) begin
					state_next = S_CHECK;
				end
			end
			S_CHECK: begin
				if (write_reg | bad_cmd) begin
					state_next = S_IDLE;
				end else begin
					state_next = S_ITEM;
				end
			end
			S_ITEM: state_next = S_CONV;
			S_CONV: begin
				if (dec_done) begin
					state_next = last_item ? S_IDLE : S_COMMA;
				end
			end
			S_COMMA: state_next = S_ITEM;
		endcase
	end

	// Sequencer state and item index
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= S_IDLE;
			idx_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			idx_reg <= cmd_take ? 3'h0 : idx_reg + 3'(comma_we);
		end
	end

	// Command capture; the snapshot freezes the modal state
	always_ff @(posedge clk) begin
		if (srst) begin
			code_reg <= 9'h000;
			write_reg <= 1'b0;
			snap_reg <= '0;
		end else if (cmd_take) begin
			code_reg <= pwdata[CMD_CODE_W-1:0];
			write_reg <= pwdata[CMD_WRITE_BIT];
			snap_reg <= modal_in;
		end
	end

	// Write value register, shared by all writable queries
	always_ff @(posedge clk) begin
		if (srst) begin
			wdata_reg <= 32'h0000_0000;
		end else if (wr_xfer & sel_wdata) begin
			wdata_reg <= pwdata;
		end
	end

	// Feedrate percent drives the motion core's feed scaling
	always_ff @(posedge clk) begin
		if (srst) begin
			feed_percent <= FEED_RESET;
		end else if (state_reg == S_CHECK & write_ok) begin
			feed_percent <= wdata_reg[6:0];
		end
	end

	// Status flags; a new command clears, but a reject in the same
	// cycle still sets the flag; a lost command clears neither flag
	always_ff @(posedge clk) begin
		if (srst) begin
			ready_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else begin
			ready_reg <= finish | (ready_reg & ~cmd_take);
			reject_reg <= cmd_lost | (state_reg == S_CHECK & bad_cmd)
				| (reject_reg & ~cmd_take);
		end
	end

	// Busy mirrors the sequencer for the motion core
	always_ff @(posedge clk) begin
		if (srst) begin
			busy <= 1'b0;
		end else begin
			busy <= state_next != S_IDLE;
		end
	end

	// ****************************************************************
	// APB response
	// ****************************************************************

	// One wait state, then pready with registered data and error
	always_ff @(posedge clk) begin
		if (srst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= load;
			if (load) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr <= ~mapped;
			end else if (xfer) begin
				pslverr <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Datapath instances
	// ****************************************************************
	// Decimal renderer, one item at a time
	dec_ascii u_dec (
		.clk(clk),
		.srst(srst),
		.start(conv_start),
		.value(conv_value),
		.ch(dec_ch),
		.ch_valid(dec_valid),
		.done(dec_done)
	);

	// Reply text store; emptied when a command is accepted
	reply_buffer #(
		.DEPTH(DEPTH)
	) u_buf (
		.clk(clk),
		.srst(srst),
		.clear(cmd_take),
		.wr_en(buf_we),
		.wr_data(buf_wdata),
		.rd_en(pop),
		.rd_data(buf_data),
		.count(buf_count)
	);
endmodule // modal_status_query_responder

// ---- modal_query_pkg.sv ----
// Shared constants and types of the modal status query responder.
// Assumes a 32-bit APB register port and one 40 MHz clock.
package modal_query_pkg;

	// ****************************************************************
	// Register map (byte offsets)
	// ****************************************************************
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_WDATA = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_REPLY = 8'h0c;
	localparam logic [7:0] REG_FEED = 8'h10;

	// Field positions
	localparam int CMD_CODE_W = 9;
	localparam int CMD_WRITE_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_REJECT_BIT = 2;
	localparam int ST_LEN_LSB = 8;
	localparam int REPLY_VALID_BIT = 8;

	// ****************************************************************
	// Query codes
	// ****************************************************************
	localparam logic [8:0] Q_MODAL = 9'h0dc;
	localparam logic [8:0] Q_UNIT = 9'h0dd;
	localparam logic [8:0] Q_POS = 9'h0de;
	localparam logic [8:0] Q_SPEED = 9'h0df;
	localparam logic [8:0] Q_FEED = 9'h0a0;
	localparam logic [8:0] Q_OFS_ALL = 9'h0be;
	localparam logic [8:0] Q_OFS_X = 9'h0bf;
	localparam logic [8:0] Q_OFS_Y = 9'h0c0;
	localparam logic [8:0] Q_OFS_Z = 9'h0c1;
	localparam logic [8:0] Q_OFS_ACT = 9'h0c2;
	localparam logic [8:0] Q_RPM = 9'h0d6;
	localparam logic [8:0] Q_VERSION = 9'h123;

	// Feedrate range and reset value, whole percent
	localparam logic [31:0] FEED_MIN = 32'h0000_0001;
	localparam logic [31:0] FEED_MAX = 32'h0000_0064;
	localparam logic [6:0] FEED_RESET = 7'h64;

	// Distance mode codes
	localparam logic [31:0] DIST_ABS = 32'h0000_0001;
	localparam logic [31:0] DIST_REL = 32'h0000_0002;

	// ASCII characters
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_MINUS = 8'h2d;
	localparam logic [7:0] CH_ZERO = 8'h30;

	// Decimal weights, highest first is index 9
	localparam int DEC_DIGITS = 10;
	localparam logic [31:0] POW10 [0:9] = '{32'h0000_0001, 32'h0000_000a,
		32'h0000_0064, 32'h0000_03e8, 32'h0000_2710, 32'h0001_86a0,
		32'h000f_4240, 32'h0098_9680, 32'h05f5_e100, 32'h3b9a_ca00};

	// Live modal state from the motion core
	typedef struct packed {
		logic [1:0] motion_code;
		logic dist_relative;
		logic [31:0] rapid_accel;
		logic [31:0] spindle_accel;
		logic unit_inch;
		logic [2:0][31:0] modal_pos;
		logic [2:0][31:0] modal_pulse;
		logic [31:0] rapid_speed;
		logic [31:0] linear_speed;
		logic [31:0] arc_speed;
		logic [31:0] spindle_speed;
		logic [2:0][31:0] offset;
		logic offset_active;
		logic [31:0] spindle_rpm;
	} modal_state_t;

endpackage

// ---- dec_ascii.sv ----
// Signed 32-bit to decimal ASCII converter, one character per pulse.
// Assumes the consumer takes every character; there is no stall.
`timescale 1ns/10ps
module dec_ascii
	import modal_query_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [31:0] value,
	output logic [7:0] ch,
	output logic ch_valid,
	output logic done
);
	typedef enum logic {D_IDLE, D_RUN} dec_state_t;
	dec_state_t state_reg;
	logic [31:0] mag_reg;
	logic [3:0] k_reg;
	logic [3:0] digit_reg;
	logic lead_reg;
	wire logic [31:0] weight = POW10[k_reg];
	wire logic fits = mag_reg >= weight;
	wire logic show = lead_reg | (digit_reg != 4'h0) | (k_reg == 4'h0);

	// Subtract weights digit by digit; slow but needs no divider
	always_ff @(posedge clk) begin
		ch_valid <= 1'b0;
		done <= 1'b0;
		if (srst) begin
			state_reg <= D_IDLE;
			mag_reg <= 32'h0000_0000;
			k_reg <= 4'h0;
			digit_reg <= 4'h0;
			lead_reg <= 1'b0;
			ch <= 8'h00;
		end else if (state_reg == D_IDLE) begin
			if (start) begin
				state_reg <= D_RUN;
				mag_reg <= value[31] ? 32'(-value) : value;
				k_reg <= 4'(DEC_DIGITS - 1);
				digit_reg <= 4'h0;
				lead_reg <= 1'b0;
				ch <= CH_MINUS;
				ch_valid <= value[31];
			end
		end else if (fits) begin
			mag_reg <= mag_reg - weight;
			digit_reg <= digit_reg + 4'h1;
		end else begin
			ch <= CH_ZERO + {4'h0, digit_reg};
			ch_valid <= show;
			lead_reg <= show;
			digit_reg <= 4'h0;
			if (k_reg == 4'h0) begin
				done <= 1'b1;
				state_reg <= D_IDLE;
			end else begin
				k_reg <= k_reg - 4'h1;
			end
		end
	end
endmodule // dec_ascii

// ---- reply_buffer.sv ----
// Character buffer holding one reply until software reads it out.
// Assumes one reply never exceeds DEPTH characters.
`timescale 1ns/10ps
module reply_buffer #(
	parameter int DEPTH = 128,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic [AW:0] count
);
	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;
	wire logic full = count == (AW+1)'(DEPTH);
	wire logic do_wr = wr_en & ~full;
	wire logic do_rd = rd_en & (count != '0);

	assign rd_data = mem[rptr_reg];

	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wptr_reg] <= wr_data;
		end
	end

	// Pointers and fill count; clear starts a fresh reply
	always_ff @(posedge clk) begin
		if (srst | clear) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count <= '0;
		end else begin
			wptr_reg <= wptr_reg + AW'(do_wr);
			rptr_reg <= rptr_reg + AW'(do_rd);
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule // reply_buffer

// ---- status_query_checker.sv ----
// Port-level checker for the modal status query responder.
// Assumes it is bound to the responder top and sees its ports only.
`timescale 1ns/10ps
module status_query_checker
	import modal_query_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [6:0] feed_percent,
	input wire logic busy
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Cycles since the last command write, saturating so it never wraps
	logic [2:0] since_cmd_reg;
	wire cmd_wr = psel && penable && pready && pwrite && paddr == REG_CMD;
	always_ff @(posedge clk) begin
		if (srst)
			since_cmd_reg <= 3'h7;
		else if (cmd_wr)
			since_cmd_reg <= 3'h0;
		else if (since_cmd_reg != 3'h7)
			since_cmd_reg <= since_cmd_reg + 3'h1;
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	a_one_wait_state: assert property (@(posedge clk) disable iff (srst)
		psel && penable && !pready |=> pready) else $error("pready late");
	a_ready_one_cycle: assert property (@(posedge clk) disable iff (srst)
		pready |=> !pready) else $error("pready held too long");
	a_ready_has_cause: assert property (@(posedge clk) disable iff (srst)
		!(psel && penable) |=> !pready) else $error("pready without access");
	a_error_with_ready: assert property (@(posedge clk) disable iff (srst)
		pslverr |-> pready) else $error("pslverr without pready");
	a_error_reads_zero: assert property (@(posedge clk) disable iff (srst)
		pready && pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("error data");
	a_feed_read_back: assert property (@(posedge clk) disable iff (srst)
		pready && !pwrite && paddr == REG_FEED |-> prdata == {25'h0, feed_percent})
		else $error("feed readback");
	a_feed_in_range: assert property (@(posedge clk) disable iff (srst)
		feed_percent >= 7'h01 && feed_percent <= 7'h64) else $error("feed out of range");
	a_feed_needs_cmd: assert property (@(posedge clk) disable iff (srst)
		$changed(feed_percent) |-> since_cmd_reg <= 3'h4 || $past(srst))
		else $error("feed changed without command");
	a_busy_bounded: assert property (@(posedge clk) disable iff (srst)
		$rose(busy) |-> ##[1:1000] !busy) else $error("busy stuck");
endmodule // status_query_checker

bind modal_status_query_responder status_query_checker u_chk (.clk(clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .feed_percent(feed_percent), .busy(busy));

// ---- motion_core_model.sv ----
// Behavioural motion core: supplies a modal state picked by scene.
// Assumes scene is held steady while a query runs.
`timescale 1ns/10ps
module motion_core_model
	import modal_query_pkg::*;
(
	input wire logic [2:0] scene,
	output modal_state_t modal_out
);
	// Odd scenes give negative values to exercise the minus sign
	function automatic logic [31:0] val(input logic [2:0] s, input int k);
		int v;
		v = k * 1111 + int'(s);
		return s[0] ? 32'(-v) : 32'(v);
	endfunction

	// Modal state; motion code only ever takes the four legal values
	always_comb begin
		modal_out.motion_code = scene[1:0];
		modal_out.dist_relative = scene[0];
		modal_out.rapid_accel = val(scene, 1);
		modal_out.spindle_accel = val(scene, 2);
		modal_out.unit_inch = scene[1];
		for (int i = 0; i < 3; i++) begin
			modal_out.modal_pos[i] = val(scene, 3 + i);
			modal_out.modal_pulse[i] = val(scene, 30 + i);
			modal_out.offset[i] = val(scene, 60 + i);
		end
		// Scene 4 carries the largest positive value
		modal_out.rapid_speed = scene == 3'h4 ? 32'h7fff_ffff : val(scene, 7);
		modal_out.linear_speed = val(scene, 8);
		modal_out.arc_speed = val(scene, 9);
		modal_out.spindle_speed = val(scene, 10);
		modal_out.offset_active = scene[0];
		modal_out.spindle_rpm = val(scene, 11);
	end
endmodule // motion_core_model

// ---- tb_top.sv ----
// Self-checking bench for the modal status query responder.
// Assumes the responder's one-wait-state APB timing and register map.
`timescale 1ns/10ps
module tb_top;
	import modal_query_pkg::*;
	localparam logic [31:0] VER = 32'h0000_0015;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, busy;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [6:0] feed_percent;
	logic [2:0] scene;
	modal_state_t m;
	int errors = 0;
	int cmp_count = 0;
	// Feedrate values written and the percent expected after each
	logic [31:0] fv [5] = '{32'h0000_0032, 32'h0000_0000, 32'h0000_0065,
		32'h0000_0001, 32'h0000_0064};
	logic [6:0] fe [5] = '{7'h32, 7'h32, 7'h32, 7'h01, 7'h64};

	motion_core_model u_core (.scene(scene), .modal_out(m));
	modal_status_query_responder #(.VERSION(VER), .DEPTH(128)) u_dut (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .modal_in(m),
		.feed_percent(feed_percent), .busy(busy));

	always #12.5 clk = ~clk;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic results();
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer; an idle cycle follows so no strobe is set twice in a step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (n == 100)
			errors++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	function automatic string dec(input logic [31:0] v);
		return $sformatf("%0d", $signed(v));
	endfunction

	// Poll STATUS until the sequencer is idle with ready or reject set
	task automatic wait_done(output logic [31:0] d);
		logic e;
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0000_0000, d, e);
			n++;
		end while (!(d[0] === 1'b0 && (d[1] === 1'b1 || d[2] === 1'b1)) && n < 3000);
		if (n == 3000)
			errors++;
		check("status_err", {31'h0, e}, 32'h0000_0000);
		check("busy_end", {31'h0, busy}, 32'h0000_0000);
	endtask

	// Issue a command word, wait for completion, then drain and compare the reply
	task automatic cmd(input logic [31:0] word, input logic rej, input string exp);
		logic [31:0] d;
		logic e;
		apb(1'b1, REG_CMD, word, d, e);
		wait_done(d);
		check("reject", {31'h0, d[2]}, {31'h0, rej});
		check("length", {24'h0, d[15:8]}, 32'(exp.len()));
		for (int i = 0; i < exp.len(); i++) begin
			apb(1'b0, REG_REPLY, 32'h0000_0000, d, e);
			check("char", {23'h0, d[8:0]}, {23'h0, 1'b1, exp[i]});
		end
		apb(1'b0, REG_REPLY, 32'h0000_0000, d, e);
		check("drained", {31'h0, d[8]}, 32'h0000_0000);
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		logic [31:0] d;
		logic e;
		clk = 1'b0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		scene = 3'h0;
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		check("feed_rst", {25'h0, feed_percent}, 32'h0000_0064);
		apb(1'b0, REG_FEED, 32'h0000_0000, d, e);
		check("feed_reg", d, 32'h0000_0064);
		// Every motion code and both distance modes, with signed values
		for (int s = 0; s < 5; s++) begin
			scene <= 3'(s);
			@(posedge clk);
			cmd({23'h0, Q_MODAL}, 1'b0, $sformatf("%0d,%0d,%s,%s", m.motion_code,
				m.dist_relative ? 2 : 1, dec(m.rapid_accel), dec(m.spindle_accel)));
			cmd({23'h0, Q_UNIT}, 1'b0, m.unit_inch ? "1" : "0");
			cmd({23'h0, Q_POS}, 1'b0, {dec(m.modal_pos[0]), ",", dec(m.modal_pos[1]), ",",
				dec(m.modal_pos[2]), ",", dec(m.modal_pulse[0]), ",",
				dec(m.modal_pulse[1]), ",", dec(m.modal_pulse[2])});
			cmd({23'h0, Q_SPEED}, 1'b0, {dec(m.rapid_speed), ",", dec(m.linear_speed),
				",", dec(m.arc_speed), ",", dec(m.spindle_speed)});
			cmd({23'h0, Q_OFS_ALL}, 1'b0, {dec(m.offset[0]), ",", dec(m.offset[1]), ",",
				dec(m.offset[2]), ",", m.offset_active ? "1" : "0"});
			for (int k = 0; k < 3; k++)
				cmd({23'h0, Q_OFS_X + 9'(k)}, 1'b0, dec(m.offset[k]));
			cmd({23'h0, Q_OFS_ACT}, 1'b0, m.offset_active ? "1" : "0");
			cmd({23'h0, Q_RPM}, 1'b0, dec(m.spindle_rpm));
		end
		cmd({23'h0, Q_VERSION}, 1'b0, dec(VER));
		// Feedrate writes: in range, both bounds, and refused values
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, REG_WDATA, fv[i], d, e);
			cmd({15'h0, 1'b1, 7'h0, Q_FEED}, fv[i] < FEED_MIN || fv[i] > FEED_MAX, "");
			check("feed_out", {25'h0, feed_percent}, {25'h0, fe[i]});
			cmd({23'h0, Q_FEED}, 1'b0, dec({25'h0, fe[i]}));
		end
		// A command written while busy is dropped and flagged; the code stays
		apb(1'b1, REG_CMD, {23'h0, Q_POS}, d, e);
		apb(1'b1, REG_CMD, {23'h0, Q_UNIT}, d, e);
		apb(1'b0, REG_CMD, 32'h0000_0000, d, e);
		check("lost_code", d, {23'h0, Q_POS});
		wait_done(d);
		check("lost_reject", {31'h0, d[2]}, 32'h0000_0001);
		// Writes to read-only queries leave state alone
		cmd({15'h0, 1'b1, 7'h0, Q_RPM}, 1'b1, "");
		cmd({15'h0, 1'b1, 7'h0, Q_UNIT}, 1'b1, "");
		check("feed_kept", {25'h0, feed_percent}, 32'h0000_0064);
		apb(1'b0, 8'h20, 32'h0000_0000, d, e);
		check("unmapped", {31'h0, e}, 32'h0000_0001);
		check("unmapped_data", d, 32'h0000_0000);
		results();
	end

	// Watchdog well past the expected run length
	initial begin
		#(25 * 95000);
		errors++;
		results();
	end
endmodule // tb_top
